// ===== hdl/debug_id_integration_regs.sv
// Debug identification registers and integration-test pin access.
// Assumes an APB3 master on the debug register port, clk at 25 MHz,
// and that the tapped pins are synchronous to clk.
//
// Notes on behaviour
// R1: Identification registers are read-only; writes never change returned values.
// R2: Identification data sits in bits 7:0; bits 31:8 read zero.
// R3: Peripheral ID 4 at 0xfd0, peripheral ID 0 to 3 at 0xfe0 to 0xfec.
// R4: Words 0xfd4 to 0xfdc are reserved and read as zero.
// R5: Peripheral ID 0 returns part number bits 7:0.
// R6: Peripheral ID 1 returns identity code low nibble and part number bits 11:8.
// R7: Peripheral ID 2 returns revision, a fixed one, identity code bits 6:4.
// R8: Peripheral ID 3 returns metal-fix revision above four zero bits.
// R9: Peripheral ID 4 returns zero block count and continuation code.
// R10: Component ID 0 to 3 at 0xff0 to 0xffc return fixed preamble bytes.
// R11: Debugger sets the mode bit before using the integration registers.
// R12: In integration mode a drive write sets restart-done, perf-interrupt, acknowledge pins.
// R13: In integration mode a sample read returns restart, interrupt and halt inputs.
// R14: Debugger applies all intended pin changes in one register write.
// R15: Mode control bit 0 selects normal (0) or integration (1); others reserved.
// R16: Debugger enters integration mode only after the core halts.
// R17: System is reset after integration testing before normal use.
// R18: With integration mode clear, output pins follow their functional sources.
`timescale 1ns/1ps
`include "dbg_id_cfg.svh"
module debug_id_integration_regs
   import dbg_id_pkg::*;
#(
   parameter logic [11:0] PART_NUMBER = 12'h2a7, // Arbitrary value
   parameter logic [6:0] JEDEC_ID = 7'h5e, // Arbitrary value
   parameter logic [3:0] JEDEC_CONT = 4'h6, // Arbitrary value
   parameter logic [3:0] REVISION = 4'h2, // Arbitrary value
   parameter logic [3:0] METAL_FIX = 4'h0 // Arbitrary value
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:2] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic func_restart_done,
   input wire logic func_perf_intr,
   input wire logic func_debug_ack,
   input wire logic restart_request_in,
   input wire logic normal_intr_in_n,
   input wire logic fast_intr_in_n,
   input wire logic ext_halt_request_in,
   output logic restart_done_out,
   output logic perf_monitor_intr_out,
   output logic debug_state_ack_out,
   output logic integration_select
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic [11:0] addr_byte;
   logic access;
   logic rd_access;
   logic wr_access;
   logic id_hit;
   logic [7:0] id_byte;
   reg_sel_t sel;
   word_t read_word;
   word_t sample_word;
   logic [2:0] drive;
   logic [2:0] next_drive;
   logic next_mode;
   logic [2:0] pin_value;

   // Word-aligned byte address; low two bits are never presented
   assign addr_byte = {paddr, 2'b00};

   // Commit cycle: one wait state, pready answers at the next edge
   assign access = psel && penable && !pready;
   assign rd_access = access && !pwrite;
   assign wr_access = access && pwrite;

   // Identification table, constants only
   id_rom #(
      .PART_NUMBER(PART_NUMBER),
      .JEDEC_ID(JEDEC_ID),
      .JEDEC_CONT(JEDEC_CONT),
      .REVISION(REVISION),
      .METAL_FIX(METAL_FIX)
   ) u_id_rom (
      .addr(addr_byte),
      .hit(id_hit),
      .id_byte(id_byte)
   );

   // Register select; identification area wins over everything
   always_comb begin
      if (id_hit) begin // see R3
         sel = SEL_ID;
      end else begin
         case (addr_byte)
            `OFF_PIN_DRIVE: sel = SEL_DRIVE;
            `OFF_PIN_SAMPLE: sel = SEL_SAMPLE;
            `OFF_MODE_CTRL: sel = SEL_CTRL;
            default: sel = SEL_NONE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Integration mode and drive register

   // Mode bit; reserved bits of the write are dropped
   always_comb begin
      if (wr_access && sel == SEL_CTRL) begin
         next_mode = pwdata[`MODE_SEL_BIT]; // see R15
      end else begin
         next_mode = integration_select;
      end
   end

   // Whole word lands at once so the three pins move together
   always_comb begin
      if (wr_access && sel == SEL_DRIVE && integration_select) begin // see R11
         next_drive = {pwdata[`DRV_RESTART_BIT], pwdata[`DRV_PERF_BIT],
                       pwdata[`DRV_ACK_BIT]}; // see R12, see R14
      end else if (!next_mode) begin
         next_drive = {3{`PIN_RST}}; // Stale overrides never reappear on re-entry
      end else begin
         next_drive = drive;
      end
   end

   // Mode register
   always_ff @(posedge clk) begin
      if (srst) begin
         integration_select <= `MODE_RST;
      end else begin
         integration_select <= next_mode;
      end
   end

   // Drive register; writes outside integration mode are dropped
   always_ff @(posedge clk) begin
      if (srst) begin
         drive <= {3{`PIN_RST}};
      end else begin
         drive <= next_drive;
      end
   end

   // Pin flops share the edge with the register update
   pin_drive u_pin_drive (
      .clk(clk),
      .srst(srst),
      .next_mode(next_mode),
      .next_drive(next_drive),
      .func_value({func_restart_done, func_perf_intr, func_debug_ack}), // see R18
      .pin_value(pin_value)
   );

   assign restart_done_out = pin_value[2];
   assign perf_monitor_intr_out = pin_value[1];
   assign debug_state_ack_out = pin_value[0];

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   // Pins sampled live at the commit edge, no synchroniser needed
   always_comb begin
      sample_word = `WORD_RST;
      sample_word[`SMP_RESTART_BIT] = restart_request_in; // see R13
      sample_word[`SMP_FAST_BIT] = fast_intr_in_n;
      sample_word[`SMP_NORMAL_BIT] = normal_intr_in_n;
      sample_word[`SMP_HALT_BIT] = ext_halt_request_in;
   end

   // Read mux; drive register is write-only and reads zero
   always_comb begin
      read_word = `WORD_RST;
      case (sel)
         SEL_ID: read_word = {24'h000000, id_byte}; // see R2
         SEL_SAMPLE: read_word = integration_select ? sample_word : `WORD_RST;
         SEL_CTRL: read_word = {31'h00000000, integration_select};
         SEL_DRIVE: read_word = `WORD_RST;
         default: read_word = `WORD_RST;
      endcase
   end

   // Read data holds until the next read commits
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= `WORD_RST;
      end else if (rd_access) begin
         prdata <= read_word; // see R1
      end
   end

   // One-cycle ready pulse per transfer
   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'b0;
      end else begin
         pready <= access;
      end
   end

   // Unmapped offsets answer with an error alongside ready
   always_ff @(posedge clk) begin
      if (srst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= access && sel == SEL_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_read(logic [11:0] a);
      rd_access && addr_byte == a;
   endsequence

   sequence s_id_write;
      wr_access && sel == SEL_ID;
   endsequence

   sequence s_drive_write;
      wr_access && sel == SEL_DRIVE && integration_select;
   endsequence

   sequence s_ctrl_write;
      wr_access && sel == SEL_CTRL;
   endsequence

   property p_read_value(logic [11:0] a, logic [31:0] v);
      s_read(a) |=> pready && !pslverr && prdata == v;
   endproperty

   // A write into the identification area cannot alter a later read of peripheral ID 1
   AST_ID_WRITE_IGNORED: assert property ( // see R1
      s_id_write ##[2:6] s_read(`OFF_PERIPH_ID_BYTE1)
      |=> prdata == {24'h000000, JEDEC_ID[3:0], PART_NUMBER[11:8]})
      else $error("identification value changed after a write");

   AST_ID_UPPER_ZERO: assert property ( // see R2
      rd_access && sel == SEL_ID |=> pready && prdata[31:8] == 24'h000000)
      else $error("identification read has nonzero upper bits");

   AST_PERIPH_ID_BYTE4_VALUE: assert property ( // see R3, see R9
      p_read_value(`OFF_PERIPH_ID_BYTE4, {24'h000000, `PERIPH_ID_BYTE4_BLOCKS_VAL, JEDEC_CONT}))
      else $error("peripheral id 4 wrong");

   AST_RSVD_ZERO: assert property ( // see R4
      rd_access && addr_byte >= `OFF_RSVD_FIRST && addr_byte <= `OFF_RSVD_LAST
      |=> pready && !pslverr && prdata == `WORD_RST)
      else $error("reserved identification word not zero");

   AST_PERIPH_ID_BYTE0_VALUE: assert property ( // see R5
      p_read_value(`OFF_PERIPH_ID_BYTE0, {24'h000000, PART_NUMBER[7:0]}))
      else $error("peripheral id 0 wrong");

   AST_PERIPH_ID_BYTE1_VALUE: assert property ( // see R6
      p_read_value(`OFF_PERIPH_ID_BYTE1, {24'h000000, JEDEC_ID[3:0], PART_NUMBER[11:8]}))
      else $error("peripheral id 1 wrong");

   AST_PERIPH_ID_BYTE2_VALUE: assert property ( // see R7
      p_read_value(`OFF_PERIPH_ID_BYTE2, {24'h000000, REVISION, `PERIPH_ID_BYTE2_FIXED_ONE, JEDEC_ID[6:4]}))
      else $error("peripheral id 2 wrong");

   AST_PERIPH_ID_BYTE3_VALUE: assert property ( // see R8
      p_read_value(`OFF_PERIPH_ID_BYTE3, {24'h000000, METAL_FIX, `PERIPH_ID_BYTE3_LOW_VAL}))
      else $error("peripheral id 3 wrong");

   AST_COMPONENT_ID_BYTE0_VALUE: assert property ( // see R10
      p_read_value(`OFF_COMPONENT_ID_BYTE0, {24'h000000, `COMPONENT_ID_BYTE0_VAL}))
      else $error("component id 0 wrong");

   AST_COMPONENT_ID_BYTE3_VALUE: assert property ( // see R10
      p_read_value(`OFF_COMPONENT_ID_BYTE3, {24'h000000, `COMPONENT_ID_BYTE3_VAL}))
      else $error("component id 3 wrong");

   AST_COMPONENT_ID_BYTE1_VALUE: assert property ( // see R10
      p_read_value(`OFF_COMPONENT_ID_BYTE1, {24'h000000, `COMPONENT_ID_BYTE1_VAL}))
      else $error("component id 1 wrong");

   AST_COMPONENT_ID_BYTE2_VALUE: assert property ( // see R10
      p_read_value(`OFF_COMPONENT_ID_BYTE2, {24'h000000, `COMPONENT_ID_BYTE2_VAL}))
      else $error("component id 2 wrong");

   // Sample register is masked to zero outside integration mode
   AST_SAMPLE_MASKED: assert property ( // see R13
      rd_access && sel == SEL_SAMPLE && !integration_select |=> prdata == `WORD_RST)
      else $error("sample register visible in normal mode");

   AST_CTRL_RESERVED: assert property ( // see R15
      rd_access && sel == SEL_CTRL |=> prdata[31:1] == 31'h00000000)
      else $error("mode control reserved bits not zero");

   // Offsets outside the map answer with an error, never silently
   AST_UNMAPPED_ERR: assert property ( // see R3
      access && sel == SEL_NONE |=> pready && pslverr)
      else $error("unmapped offset accepted without error");

   // Checked through reset itself, so the default disable is overridden
   AST_RESET_STATE: assert property (disable iff (1'b0) // see R15
      srst |=> !integration_select && !pready && !pslverr && prdata == `WORD_RST
      && !restart_done_out && !perf_monitor_intr_out && !debug_state_ack_out)
      else $error("reset state wrong");

   // All three pins follow one write on the same edge
   AST_DRIVE_PINS: assert property ( // see R12, see R14
      s_drive_write |=> restart_done_out == $past(pwdata[`DRV_RESTART_BIT])
      && perf_monitor_intr_out == $past(pwdata[`DRV_PERF_BIT])
      && debug_state_ack_out == $past(pwdata[`DRV_ACK_BIT]))
      else $error("integration drive write did not reach the pins");

   AST_SAMPLE_PINS: assert property ( // see R13
      rd_access && sel == SEL_SAMPLE && integration_select
      |=> prdata[`SMP_RESTART_BIT] == $past(restart_request_in)
      && prdata[`SMP_FAST_BIT] == $past(fast_intr_in_n)
      && prdata[`SMP_NORMAL_BIT] == $past(normal_intr_in_n)
      && prdata[`SMP_HALT_BIT] == $past(ext_halt_request_in))
      else $error("integration sample read wrong");

   // Mode follows the write and reads back within a few cycles
   AST_MODE_BIT: assert property ( // see R15
      s_ctrl_write ##1 (integration_select == $past(pwdata[`MODE_SEL_BIT]))
      ##[1:4] s_read(`OFF_MODE_CTRL)
      |=> prdata == {31'h00000000, $past(integration_select)})
      else $error("mode control bit not stored or read back");

   AST_NORMAL_PASS: assert property ( // see R18
      !integration_select && !(wr_access && sel == SEL_CTRL && pwdata[`MODE_SEL_BIT])
      |=> restart_done_out == $past(func_restart_done)
      && perf_monitor_intr_out == $past(func_perf_intr)
      && debug_state_ack_out == $past(func_debug_ack))
      else $error("functional pins not passed through in normal mode");

   AST_READY_PULSE: assert property (
      access |=> pready ##1 !pready)
      else $error("ready is not a single-cycle answer");

endmodule

// ===== hdl/dbg_id_cfg.svh
// Constants for the debug identification and integration-test block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef DBG_ID_CFG_SVH
`define DBG_ID_CFG_SVH

// Byte offsets inside the 4 KB debug register page
`define OFF_PERIPH_ID_BYTE4 12'hfd0
`define OFF_RSVD_FIRST 12'hfd4
`define OFF_RSVD_MID 12'hfd8
`define OFF_RSVD_LAST 12'hfdc
`define OFF_PERIPH_ID_BYTE0 12'hfe0
`define OFF_PERIPH_ID_BYTE1 12'hfe4
`define OFF_PERIPH_ID_BYTE2 12'hfe8
`define OFF_PERIPH_ID_BYTE3 12'hfec
`define OFF_COMPONENT_ID_BYTE0 12'hff0
`define OFF_COMPONENT_ID_BYTE1 12'hff4
`define OFF_COMPONENT_ID_BYTE2 12'hff8
`define OFF_COMPONENT_ID_BYTE3 12'hffc
`define OFF_PIN_DRIVE 12'hef8
`define OFF_PIN_SAMPLE 12'hefc
`define OFF_MODE_CTRL 12'hf00

// Fixed identification content
`define COMPONENT_ID_BYTE0_VAL 8'h0d
`define COMPONENT_ID_BYTE1_VAL 8'h90
`define COMPONENT_ID_BYTE2_VAL 8'h05
`define COMPONENT_ID_BYTE3_VAL 8'hb1
`define PERIPH_ID_BYTE2_FIXED_ONE 1'b1
`define PERIPH_ID_BYTE3_LOW_VAL 4'h0
`define PERIPH_ID_BYTE4_BLOCKS_VAL 4'h0

// Field positions of the integration registers
`define DRV_RESTART_BIT 9
`define DRV_PERF_BIT 4
`define DRV_ACK_BIT 0
`define SMP_RESTART_BIT 11
`define SMP_FAST_BIT 2
`define SMP_NORMAL_BIT 1
`define SMP_HALT_BIT 0
`define MODE_SEL_BIT 0

// Reset values
`define WORD_RST 32'h0000_0000
`define MODE_RST 1'b0
`define PIN_RST 1'b0

`endif

// ===== hdl/dbg_id_pkg.sv
// Types shared by the debug identification block.
// Assumes nothing of its surroundings.
package dbg_id_pkg;
   typedef logic [31:0] word_t;
   typedef enum {SEL_NONE, SEL_ID, SEL_DRIVE, SEL_SAMPLE, SEL_CTRL} reg_sel_t;
endpackage

// ===== hdl/id_rom.sv
// Constant lookup of identification bytes by byte offset.
// Assumes the caller qualifies the lookup with a read access.
`timescale 1ns/1ps
`include "dbg_id_cfg.svh"
module id_rom #(
   parameter logic [11:0] PART_NUMBER = 12'h2a7, // Arbitrary value
   parameter logic [6:0] JEDEC_ID = 7'h5e, // Arbitrary value
   parameter logic [3:0] JEDEC_CONT = 4'h6, // Arbitrary value
   parameter logic [3:0] REVISION = 4'h2, // Arbitrary value
   parameter logic [3:0] METAL_FIX = 4'h0 // Arbitrary value
) (
   input wire logic [11:0] addr,
   output logic hit,
   output logic [7:0] id_byte
);
   // Pure table; reserved slots hit but return zero
   always_comb begin
      hit = 1'b1;
      id_byte = 8'h00;
      case (addr)
         `OFF_PERIPH_ID_BYTE4: id_byte = {`PERIPH_ID_BYTE4_BLOCKS_VAL, JEDEC_CONT}; // see R9
         `OFF_RSVD_FIRST, `OFF_RSVD_MID, `OFF_RSVD_LAST: id_byte = 8'h00; // see R4
         `OFF_PERIPH_ID_BYTE0: id_byte = PART_NUMBER[7:0]; // see R5
         `OFF_PERIPH_ID_BYTE1: id_byte = {JEDEC_ID[3:0], PART_NUMBER[11:8]}; // see R6
         `OFF_PERIPH_ID_BYTE2: id_byte = {REVISION, `PERIPH_ID_BYTE2_FIXED_ONE, JEDEC_ID[6:4]}; // see R7
         `OFF_PERIPH_ID_BYTE3: id_byte = {METAL_FIX, `PERIPH_ID_BYTE3_LOW_VAL}; // see R8
         `OFF_COMPONENT_ID_BYTE0: id_byte = `COMPONENT_ID_BYTE0_VAL; // see R10
         `OFF_COMPONENT_ID_BYTE1: id_byte = `COMPONENT_ID_BYTE1_VAL; // see R10
         `OFF_COMPONENT_ID_BYTE2: id_byte = `COMPONENT_ID_BYTE2_VAL; // see R10
         `OFF_COMPONENT_ID_BYTE3: id_byte = `COMPONENT_ID_BYTE3_VAL; // see R10
         default: hit = 1'b0;
      endcase
   end
endmodule

// ===== hdl/pin_drive.sv
// Output pin flops: functional source or integration override.
// Assumes next_mode and drive values are the register's next state.
`timescale 1ns/1ps
`include "dbg_id_cfg.svh"
module pin_drive (
   input wire logic clk,
   input wire logic srst,
   input wire logic next_mode,
   input wire logic [2:0] next_drive,
   input wire logic [2:0] func_value,
   output logic [2:0] pin_value
);
   // Mux ahead of the flop so the pins are glitch-free
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_value <= {3{`PIN_RST}};
      end else if (next_mode) begin
         pin_value <= next_drive;
      end else begin
         pin_value <= func_value;
      end
   end
endmodule

// ===== verification/dbg_master.sv
// Debugger model for the debug register port of the identification block.
// Assumes a one-cycle pready after the access phase; drives at falling edges.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
module dbg_master (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:2] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h000;
      pwdata = 32'h0000_0000;
   end
   // One transfer; request held until the rising edge that sees pready
   task automatic xfer(input logic wr, input logic [11:0] off, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(negedge clk);
      psel = 1'b1;
      pwrite = wr;
      paddr = off[11:2];
      pwdata = wd;
      @(negedge clk);
      penable = 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16); // Bounded so a dead port cannot hang
      rd = prdata;
      err = pslverr;
      @(negedge clk);
      psel = 1'b0;
      penable = 1'b0;
      // Released address and write data never keep the last value; pwrite does
      paddr = ~paddr;
      pwdata = ~pwdata;
   endtask
endmodule

// ===== verification/debug_id_integration_regs_tb_top.sv
// Self-checking bench for the identification and integration-test block.
// Assumes the debugger model drives the register port at falling edges.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
module debug_id_integration_regs_tb_top;
   import dbg_id_pkg::*;
   localparam logic [11:0] PART = 12'h6d1; // Arbitrary value
   localparam logic [6:0] JID = 7'h2a; // Arbitrary value
   localparam logic [3:0] CONT = 4'h9; // Arbitrary value
   localparam logic [3:0] REV = 4'h7; // Arbitrary value
   localparam logic [3:0] MFIX = 4'h8; // Arbitrary value
   // Expected words from 0xfd0 upward, worked out from the field layout
   localparam logic [31:0] ID_EXP [12] = '{{24'h0, 4'h0, CONT}, 32'h0, 32'h0, 32'h0,
      {24'h0, PART[7:0]}, {24'h0, JID[3:0], PART[11:8]}, {24'h0, REV, 1'b1, JID[6:4]},
      {24'h0, MFIX, 4'h0}, 32'h0d, 32'h90, 32'h05, 32'hb1};
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [11:2] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] fsrc = 3'h0; // Functional sources: restart done, perf, ack
   logic [3:0] pin_in = 4'h0; // Restart, fast_n, normal_n, halt
   logic restart_done_out, perf_monitor_intr_out, debug_state_ack_out, integration_select;
   logic [2:0] pins;
   int n_fail = 0;
   int compares = 0;
   assign pins = {restart_done_out, perf_monitor_intr_out, debug_state_ack_out};
   always #20 clk = ~clk;
   //////////////////////////////////////////////////////////////////////
   debug_id_integration_regs #(.PART_NUMBER(PART), .JEDEC_ID(JID), .JEDEC_CONT(CONT),
      .REVISION(REV), .METAL_FIX(MFIX)) i_debug_id_integration_regs (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .func_restart_done(fsrc[2]), .func_perf_intr(fsrc[1]), .func_debug_ack(fsrc[0]),
      .restart_request_in(pin_in[3]), .fast_intr_in_n(pin_in[2]),
      .normal_intr_in_n(pin_in[1]), .ext_halt_request_in(pin_in[0]),
      .restart_done_out(restart_done_out), .perf_monitor_intr_out(perf_monitor_intr_out),
      .debug_state_ack_out(debug_state_ack_out), .integration_select(integration_select));
   dbg_master i_dbg_master (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   //////////////////////////////////////////////////////////////////////
   // Single comparison point
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd_chk(input logic [11:0] off, input logic [31:0] exp, input string what);
      i_dbg_master.xfer(1'b0, off, 32'h0, rd, err);
      chk(what, rd, exp);
      chk("pslverr", {31'h0, err}, 32'h0);
   endtask
   task automatic wr(input logic [11:0] off, input logic [31:0] wd);
      i_dbg_master.xfer(1'b1, off, wd, rd, err);
   endtask
   task automatic complete_run;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   // Watchdog: whole sequence needs well under a thousand cycles
   initial begin
      #(40 * 4000);
      n_fail++;
      complete_run();
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk) srst = 1'b0;
      for (int i = 0; i < 12; i++) rd_chk(12'hfd0 + 12'(i * 4), ID_EXP[i], "id word");
      for (int i = 0; i < 12; i++) begin
         wr(12'hfd0 + 12'(i * 4), 32'hffff_ffff);
         rd_chk(12'hfd0 + 12'(i * 4), ID_EXP[i], "id after write");
      end
      i_dbg_master.xfer(1'b0, 12'h004, 32'h0, rd, err);
      chk("unmapped error", {31'h0, err}, 32'h1);
      // Normal mode: drive writes ignored, pins follow sources a cycle late
      wr(12'hef8, 32'h0000_0211);
      rd_chk(12'hef8, 32'h0, "drive reads zero");
      for (int v = 0; v < 8; v++) begin
         @(negedge clk) fsrc = 3'(v);
         @(negedge clk);
         chk("pins normal", {29'h0, pins}, 32'(v));
      end
      @(negedge clk) pin_in = 4'hf;
      rd_chk(12'hefc, 32'h0, "sample mode clear");
      // Enter integration mode; reserved bits must not stick
      wr(12'hf00, 32'hffff_ffff);
      rd_chk(12'hf00, 32'h1, "mode readback");
      chk("mode pin", {31'h0, integration_select}, 32'h1);
      for (int v = 0; v < 8; v++) begin
         @(negedge clk) fsrc = ~3'(v); // Sources opposite to show the override
         wr(12'hef8, {22'h0, 1'(v >> 2), 4'h0, 1'(v >> 1), 3'h0, 1'(v)});
         chk("pins driven", {29'h0, pins}, 32'(v));
      end
      for (int v = 0; v < 16; v++) begin
         @(negedge clk) pin_in = 4'(v);
         rd_chk(12'hefc, {20'h0, pin_in[3], 8'h0, pin_in[2:0]}, "sample");
      end
      // Leave integration mode: pins back to their sources
      wr(12'hf00, 32'h0);
      chk("mode off", {31'h0, integration_select}, 32'h0);
      @(negedge clk) fsrc = 3'h5;
      @(negedge clk);
      chk("pins released", {29'h0, pins}, 32'h5);
      // Reset after integration use clears everything
      wr(12'hf00, 32'h1);
      wr(12'hef8, 32'h0000_0211);
      chk("pins all driven", {29'h0, pins}, 32'h7);
      @(negedge clk);
      fsrc = 3'h0;
      srst = 1'b1;
      @(negedge clk);
      chk("pins in reset", {29'h0, pins}, 32'h0);
      chk("mode in reset", {31'h0, integration_select}, 32'h0);
      chk("prdata in reset", prdata, 32'h0);
      srst = 1'b0;
      complete_run();
   end
endmodule
